// ===== rtl/cod_decoder.sv
`timescale 1ns/1ps
// Function
// - Add 04 takes source byte, then destination
// - Register field 0-255, escaped selects working register
// - Bit index is three bits, 0 to 7
// - Extended register operand is twelve bits
// - Direct target is sixteen-bit program address
// - Immediate is one byte from stream
// - Register pair operand must be even
// - Working pair only even numbers 0 to 14
// - Polarity is one bit written or compared
// - AND 52-57, wide AND 58-59, Z S V
// - Lock 2F shields next three instructions
// - E2 bit write; clear, set, or polarity
// - D5 reverses bits, carry undefined
// - F6/F7 three-byte bit test branch
// - Clear/set branches are fixed-polarity bit tests
// - Call pushes PC, SP minus two, jumps
// - EF inverts carry only
module cod_decoder (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic pc_load,
  input wire logic [15:0] pc_load_addr,
  output logic dec_valid,
  output logic dec_illegal,
  output logic [7:0] dec_opcode,
  output cod_pkg::cod_op_e dec_op,
  output logic [2:0] dec_len,
  output cod_pkg::cod_mode_e dst_mode,
  output logic dst_work,
  output logic [11:0] dst_addr,
  output cod_pkg::cod_mode_e src_mode,
  output logic src_work,
  output logic [11:0] src_addr,
  output logic [7:0] dec_imm,
  output logic [2:0] dec_bit,
  output logic dec_pol,
  output logic [7:0] dec_disp,
  output logic [15:0] dec_target,
  output logic [15:0] dec_next_pc,
  output logic [7:0] dec_sp_dec,
  output logic pair_err,
  output cod_pkg::cod_flag_e fm_c,
  output cod_pkg::cod_flag_e fm_z,
  output cod_pkg::cod_flag_e fm_s,
  output cod_pkg::cod_flag_e fm_v,
  output cod_pkg::cod_flag_e fm_d,
  output cod_pkg::cod_flag_e fm_h,
  output logic irq_block
);

  // Byte gathering states
  typedef enum logic {ST_OPCODE, ST_OPERAND} cod_state_e;

  cod_state_e st_q, st_d; // Gathering state
  logic [1:0] cnt_q, cnt_d; // Next byte slot
  logic [7:0] buf_q [4]; // Instruction bytes, opcode first
  logic [7:0] buf_d [4];
  logic [15:0] pc_q, pc_d; // Address of the next byte to arrive
  logic done; // Last byte of an instruction taken this cycle
  logic [7:0] tbl_opc; // Opcode fed to the table
  cod_pkg::cod_op_e tbl_op; // Table class
  logic [2:0] tbl_len; // Table length
  cod_pkg::cod_mode_e tbl_dst, tbl_src; // Table operand forms
  logic tbl_known; // Opcode is in the subset
  cod_pkg::cod_op_e op_d; // Class refined by polarity
  cod_pkg::cod_flag_e fc, fz, fs, fv, fd, fh; // Flag effects of op_d
  logic [12:0] rf1, rf2; // Escape-decoded fields of bytes 1 and 2

  // Output registers
  logic valid_q, illegal_q, dwork_q, dwork_d, swork_q, swork_d, pol_q, pol_d, perr_q, perr_d;
  logic [7:0] opc_q, imm_q, imm_d, disp_q, disp_d, spd_q, spd_d;
  logic [2:0] len_q, bit_q, bit_d;
  logic [11:0] daddr_q, daddr_d, saddr_q, saddr_d;
  logic [15:0] tgt_q, tgt_d, npc_q;
  cod_pkg::cod_op_e op_q;
  cod_pkg::cod_mode_e dmode_q, smode_q;
  cod_pkg::cod_flag_e fc_q, fz_q, fs_q, fv_q, fd_q, fh_q;
  logic [1:0] lock_q, lock_d; // Instructions still shielded
  logic block_q, block_d;

  // During the opcode byte the table looks at the live byte
  assign tbl_opc = (st_q == ST_OPCODE) ? byte_data : buf_q[0];

  cod_op_table u_table (
    .opcode(tbl_opc),
    .op(tbl_op),
    .len(tbl_len),
    .dst_mode(tbl_dst),
    .src_mode(tbl_src),
    .known(tbl_known)
  );

  cod_flag_map u_flags (
    .op(op_d),
    .fm_c(fc),
    .fm_z(fz),
    .fm_s(fs),
    .fm_v(fv),
    .fm_d(fd),
    .fm_h(fh)
  );

  // Byte gathering: counts bytes against the table length
  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    buf_d = buf_q;
    pc_d = pc_q;
    done = 1'b0;
    if (pc_load)
    begin
      // A jump in the fetch stream drops any partial instruction
      pc_d = pc_load_addr;
      st_d = ST_OPCODE;
      cnt_d = 2'h0;
    end
    else if (byte_valid)
    begin
      pc_d = pc_q + 16'h0001;
      buf_d[cnt_q] = byte_data;
      case (st_q)
        ST_OPCODE:
        begin
          buf_d[1] = 8'h00; // Stale operands never leak into short forms
          buf_d[2] = 8'h00;
          buf_d[3] = 8'h00;
          if (tbl_len == cod_pkg::LEN_1)
            done = 1'b1;
          else
          begin
            st_d = ST_OPERAND;
            cnt_d = 2'h1;
          end
        end
        ST_OPERAND:
        begin
          if ((3'(cnt_q) + 3'h1) == tbl_len)
          begin
            done = 1'b1;
            st_d = ST_OPCODE;
            cnt_d = 2'h0;
          end
          else
            cnt_d = cnt_q + 2'h1;
        end
        default:
        begin
          st_d = ST_OPCODE;
          cnt_d = 2'h0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q <= ST_OPCODE;
      cnt_q <= 2'h0;
      pc_q <= 16'h0000;
      for (int i = 0; i < 4; i++)
        buf_q[i] <= 8'h00;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      pc_q <= pc_d;
      buf_q <= buf_d;
    end
  end

  assign rf1 = cod_pkg::reg_field(buf_d[1]);
  assign rf2 = cod_pkg::reg_field(buf_d[2]);

  // Operand decode from the completed byte set
  always_comb
  begin
    op_d = tbl_op;
    dwork_d = 1'b0;
    swork_d = 1'b0;
    daddr_d = 12'h000;
    saddr_d = 12'h000;
    imm_d = 8'h00;
    bit_d = buf_d[1][cod_pkg::FLD_BIT_HI:cod_pkg::FLD_BIT_LO];
    pol_d = buf_d[1][cod_pkg::FLD_POL];
    disp_d = 8'h00;
    tgt_d = 16'h0000;
    spd_d = 8'h00;
    perr_d = 1'b0;
    case (buf_d[0])
      cod_pkg::OPC_ADD_RR, cod_pkg::OPC_AND_RR, cod_pkg::OPC_AND_RIR:
      begin
        // Source comes first in the stream
        {swork_d, saddr_d} = rf1;
        {dwork_d, daddr_d} = rf2;
      end
      cod_pkg::OPC_AND_WW, cod_pkg::OPC_AND_WI:
      begin
        dwork_d = 1'b1;
        swork_d = 1'b1;
        daddr_d = cod_pkg::work_field(buf_d[1][7:4]);
        saddr_d = cod_pkg::work_field(buf_d[1][3:0]);
      end
      cod_pkg::OPC_AND_RIM, cod_pkg::OPC_AND_IRIM:
      begin
        {dwork_d, daddr_d} = rf1;
        imm_d = buf_d[2];
      end
      cod_pkg::OPC_WIDE_AND_OP_EE:
      begin
        saddr_d = {buf_d[1], buf_d[2][7:4]};
        daddr_d = {buf_d[2][3:0], buf_d[3]};
      end
      cod_pkg::OPC_WIDE_AND_OP_EIM:
      begin
        imm_d = buf_d[1];
        daddr_d = {buf_d[2][3:0], buf_d[3]};
      end
      cod_pkg::OPC_BITW:
      begin
        // Polarity picks the clear or set flavour
        op_d = pol_d ? cod_pkg::OP_SET_BIT_OP : cod_pkg::OP_CLEAR_BIT_OP;
        dwork_d = 1'b1;
        daddr_d = cod_pkg::work_field(buf_d[1][3:0]);
      end
      cod_pkg::OPC_BIT_REVERSE_OP:
      begin
        {dwork_d, daddr_d} = rf1;
      end
      cod_pkg::OPC_BTJ_W, cod_pkg::OPC_BTJ_IW:
      begin
        // Taken when the source bit equals the polarity
        op_d = pol_d ? cod_pkg::OP_BRANCH_IF_BIT_SET : cod_pkg::OP_BRANCH_IF_BIT_CLEAR;
        swork_d = 1'b1;
        saddr_d = cod_pkg::work_field(buf_d[1][3:0]);
        disp_d = buf_d[2];
        tgt_d = pc_d + {{8{buf_d[2][7]}}, buf_d[2]};
      end
      cod_pkg::OPC_CALL_IRR:
      begin
        // Target comes from the pair contents, read by execute
        {dwork_d, daddr_d} = rf1;
        perr_d = buf_d[1][0];
        spd_d = cod_pkg::CALL_SP_DEC;
      end
      cod_pkg::OPC_CALL_DA:
      begin
        tgt_d = {buf_d[1], buf_d[2]};
        spd_d = cod_pkg::CALL_SP_DEC;
      end
      default:
      begin
        bit_d = 3'h0; // No operands for lock, carry flip or unknowns
        pol_d = 1'b0;
      end
    endcase
  end

  // Results are held until the next instruction completes
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      valid_q <= 1'b0;
      illegal_q <= 1'b0;
      opc_q <= 8'h00;
      op_q <= cod_pkg::OP_NONE;
      len_q <= 3'h0;
      dmode_q <= cod_pkg::MD_NONE;
      smode_q <= cod_pkg::MD_NONE;
      dwork_q <= 1'b0;
      swork_q <= 1'b0;
      daddr_q <= 12'h000;
      saddr_q <= 12'h000;
      imm_q <= 8'h00;
      bit_q <= 3'h0;
      pol_q <= 1'b0;
      disp_q <= 8'h00;
      tgt_q <= 16'h0000;
      npc_q <= 16'h0000;
      spd_q <= 8'h00;
      perr_q <= 1'b0;
      fc_q <= cod_pkg::FM_KEEP;
      fz_q <= cod_pkg::FM_KEEP;
      fs_q <= cod_pkg::FM_KEEP;
      fv_q <= cod_pkg::FM_KEEP;
      fd_q <= cod_pkg::FM_KEEP;
      fh_q <= cod_pkg::FM_KEEP;
    end
    else
    begin
      valid_q <= done;
      if (done)
      begin
        illegal_q <= !tbl_known;
        opc_q <= buf_d[0];
        op_q <= op_d;
        len_q <= tbl_len;
        dmode_q <= tbl_dst;
        smode_q <= tbl_src;
        dwork_q <= dwork_d;
        swork_q <= swork_d;
        daddr_q <= daddr_d;
        saddr_q <= saddr_d;
        imm_q <= imm_d;
        bit_q <= bit_d;
        pol_q <= pol_d;
        disp_q <= disp_d;
        tgt_q <= tgt_d;
        npc_q <= pc_d; // Return address of a call
        spd_q <= spd_d;
        perr_q <= perr_d;
        fc_q <= fc;
        fz_q <= fz;
        fs_q <= fs;
        fv_q <= fv;
        fd_q <= fd;
        fh_q <= fh;
      end
    end
  end

  // Lock window: counts the instructions that follow a lock
  always_comb
  begin
    lock_d = lock_q;
    if (done && (op_d == cod_pkg::OP_LOCK))
      lock_d = cod_pkg::LOCK_COUNT;
    else if (done && (lock_q != 2'h0))
      lock_d = lock_q - 2'h1;
    // Still shielded while the third instruction is handed to execute
    block_d = (lock_d != 2'h0) || (lock_q != 2'h0);
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      lock_q <= 2'h0;
      block_q <= 1'b0;
    end
    else
    begin
      lock_q <= lock_d;
      block_q <= block_d;
    end
  end

  assign dec_valid = valid_q;
  assign dec_illegal = illegal_q;
  assign dec_opcode = opc_q;
  assign dec_op = op_q;
  assign dec_len = len_q;
  assign dst_mode = dmode_q;
  assign dst_work = dwork_q;
  assign dst_addr = daddr_q;
  assign src_mode = smode_q;
  assign src_work = swork_q;
  assign src_addr = saddr_q;
  assign dec_imm = imm_q;
  assign dec_bit = bit_q;
  assign dec_pol = pol_q;
  assign dec_disp = disp_q;
  assign dec_target = tgt_q;
  assign dec_next_pc = npc_q;
  assign dec_sp_dec = spd_q;
  assign pair_err = perr_q;
  assign fm_c = fc_q;
  assign fm_z = fz_q;
  assign fm_s = fs_q;
  assign fm_v = fv_q;
  assign fm_d = fd_q;
  assign fm_h = fh_q;
  assign irq_block = block_q;

endmodule : cod_decoder

// ===== rtl/cod_pkg.sv
package cod_pkg;

  // Opcodes of the decoded subset
  localparam logic [7:0] OPC_ADD_RR = 8'h04;
  localparam logic [7:0] OPC_AND_WW = 8'h52;
  localparam logic [7:0] OPC_AND_WI = 8'h53;
  localparam logic [7:0] OPC_AND_RR = 8'h54;
  localparam logic [7:0] OPC_AND_RIR = 8'h55;
  localparam logic [7:0] OPC_AND_RIM = 8'h56;
  localparam logic [7:0] OPC_AND_IRIM = 8'h57;
  localparam logic [7:0] OPC_WIDE_AND_OP_EE = 8'h58;
  localparam logic [7:0] OPC_WIDE_AND_OP_EIM = 8'h59;
  localparam logic [7:0] OPC_LOCK = 8'h2F;
  localparam logic [7:0] OPC_BITW = 8'hE2;
  localparam logic [7:0] OPC_BIT_REVERSE_OP = 8'hD5;
  localparam logic [7:0] OPC_BTJ_W = 8'hF6;
  localparam logic [7:0] OPC_BTJ_IW = 8'hF7;
  localparam logic [7:0] OPC_CALL_IRR = 8'hD4;
  localparam logic [7:0] OPC_CALL_DA = 8'hD6;
  localparam logic [7:0] OPC_CCF = 8'hEF;

  // Instruction lengths in bytes
  localparam logic [2:0] LEN_1 = 3'h1;
  localparam logic [2:0] LEN_2 = 3'h2;
  localparam logic [2:0] LEN_3 = 3'h3;
  localparam logic [2:0] LEN_4 = 3'h4;

  // Escape nibble that turns an 8-bit register field into a working register
  localparam logic [3:0] ESC_NIBBLE = 4'hE;

  // Bit operand byte layout: polarity, bit index, working register
  localparam int FLD_POL = 7;
  localparam int FLD_BIT_HI = 6;
  localparam int FLD_BIT_LO = 4;

  // Instructions shielded from interrupts and DMA after a lock
  localparam logic [1:0] LOCK_COUNT = 2'h3;

  // Stack pointer decrement of a call
  localparam logic [7:0] CALL_SP_DEC = 8'h02;

  // Operation classes
  typedef enum logic [3:0] {
    OP_NONE, OP_ADD, OP_AND, OP_WIDE_AND_OP, OP_LOCK, OP_CLEAR_BIT_OP, OP_SET_BIT_OP,
    OP_BIT_REVERSE_OP, OP_BRANCH_IF_BIT_CLEAR, OP_BRANCH_IF_BIT_SET, OP_CALL, OP_CCF
  } cod_op_e;

  // Per-flag effect handed to the execute stage
  typedef enum logic [2:0] {
    FM_KEEP, FM_RESULT, FM_CLEAR, FM_UNDEF, FM_INVERT
  } cod_flag_e;

  // Operand addressing forms
  typedef enum logic [2:0] {
    MD_NONE, MD_WORK, MD_IWORK, MD_REG, MD_IREG, MD_EXT, MD_IMM, MD_PAIR
  } cod_mode_e;

  // 8-bit register field: returns {escaped, 12-bit address}
  function automatic logic [12:0] reg_field(input logic [7:0] b);
    if (b[7:4] == ESC_NIBBLE)
      reg_field = {1'b1, 8'h00, b[3:0]};
    else
      reg_field = {1'b0, 4'h0, b};
  endfunction : reg_field

  // Working register number widened to the address width
  function automatic logic [11:0] work_field(input logic [3:0] n);
    work_field = {8'h00, n};
  endfunction : work_field

endpackage : cod_pkg

// ===== rtl/cod_op_table.sv
`timescale 1ns/1ps
// Opcode lookup: class, length and operand forms
module cod_op_table (
  input wire logic [7:0] opcode,
  output cod_pkg::cod_op_e op,
  output logic [2:0] len,
  output cod_pkg::cod_mode_e dst_mode,
  output cod_pkg::cod_mode_e src_mode,
  output logic known
);

  // Pure lookup; unknown opcodes take one byte so the stream keeps moving
  always_comb
  begin
    op = cod_pkg::OP_NONE;
    len = cod_pkg::LEN_1;
    dst_mode = cod_pkg::MD_NONE;
    src_mode = cod_pkg::MD_NONE;
    known = 1'b1;
    case (opcode)
      cod_pkg::OPC_ADD_RR:
      begin
        op = cod_pkg::OP_ADD; len = cod_pkg::LEN_3;
        dst_mode = cod_pkg::MD_REG; src_mode = cod_pkg::MD_REG;
      end
      cod_pkg::OPC_AND_WW:
      begin
        op = cod_pkg::OP_AND; len = cod_pkg::LEN_2;
        dst_mode = cod_pkg::MD_WORK; src_mode = cod_pkg::MD_WORK;
      end
      cod_pkg::OPC_AND_WI:
      begin
        op = cod_pkg::OP_AND; len = cod_pkg::LEN_2;
        dst_mode = cod_pkg::MD_WORK; src_mode = cod_pkg::MD_IWORK;
      end
      cod_pkg::OPC_AND_RR:
      begin
        op = cod_pkg::OP_AND; len = cod_pkg::LEN_3;
        dst_mode = cod_pkg::MD_REG; src_mode = cod_pkg::MD_REG;
      end
      cod_pkg::OPC_AND_RIR:
      begin
        op = cod_pkg::OP_AND; len = cod_pkg::LEN_3;
        dst_mode = cod_pkg::MD_REG; src_mode = cod_pkg::MD_IREG;
      end
      cod_pkg::OPC_AND_RIM:
      begin
        op = cod_pkg::OP_AND; len = cod_pkg::LEN_3;
        dst_mode = cod_pkg::MD_REG; src_mode = cod_pkg::MD_IMM;
      end
      cod_pkg::OPC_AND_IRIM:
      begin
        op = cod_pkg::OP_AND; len = cod_pkg::LEN_3;
        dst_mode = cod_pkg::MD_IREG; src_mode = cod_pkg::MD_IMM;
      end
      cod_pkg::OPC_WIDE_AND_OP_EE:
      begin
        op = cod_pkg::OP_WIDE_AND_OP; len = cod_pkg::LEN_4;
        dst_mode = cod_pkg::MD_EXT; src_mode = cod_pkg::MD_EXT;
      end
      cod_pkg::OPC_WIDE_AND_OP_EIM:
      begin
        op = cod_pkg::OP_WIDE_AND_OP; len = cod_pkg::LEN_4;
        dst_mode = cod_pkg::MD_EXT; src_mode = cod_pkg::MD_IMM;
      end
      cod_pkg::OPC_LOCK:
      begin
        op = cod_pkg::OP_LOCK;
      end
      cod_pkg::OPC_BITW:
      begin
        op = cod_pkg::OP_SET_BIT_OP; len = cod_pkg::LEN_2;
        dst_mode = cod_pkg::MD_WORK;
      end
      cod_pkg::OPC_BIT_REVERSE_OP:
      begin
        op = cod_pkg::OP_BIT_REVERSE_OP; len = cod_pkg::LEN_2;
        dst_mode = cod_pkg::MD_REG;
      end
      cod_pkg::OPC_BTJ_W:
      begin
        op = cod_pkg::OP_BRANCH_IF_BIT_SET; len = cod_pkg::LEN_3;
        src_mode = cod_pkg::MD_WORK;
      end
      cod_pkg::OPC_BTJ_IW:
      begin
        op = cod_pkg::OP_BRANCH_IF_BIT_SET; len = cod_pkg::LEN_3;
        src_mode = cod_pkg::MD_IWORK;
      end
      cod_pkg::OPC_CALL_IRR:
      begin
        op = cod_pkg::OP_CALL; len = cod_pkg::LEN_2;
        dst_mode = cod_pkg::MD_PAIR;
      end
      cod_pkg::OPC_CALL_DA:
      begin
        op = cod_pkg::OP_CALL; len = cod_pkg::LEN_3;
        dst_mode = cod_pkg::MD_IMM;
      end
      cod_pkg::OPC_CCF:
      begin
        op = cod_pkg::OP_CCF;
      end
      default:
      begin
        known = 1'b0; // Outside the subset
      end
    endcase
  end

endmodule : cod_op_table

// ===== rtl/cod_flag_map.sv
`timescale 1ns/1ps
// Operation class to per-flag effect
module cod_flag_map (
  input cod_pkg::cod_op_e op,
  output cod_pkg::cod_flag_e fm_c,
  output cod_pkg::cod_flag_e fm_z,
  output cod_pkg::cod_flag_e fm_s,
  output cod_pkg::cod_flag_e fm_v,
  output cod_pkg::cod_flag_e fm_d,
  output cod_pkg::cod_flag_e fm_h
);

  // Decimal and half-carry are never touched by this subset
  always_comb
  begin
    fm_c = cod_pkg::FM_KEEP;
    fm_z = cod_pkg::FM_KEEP;
    fm_s = cod_pkg::FM_KEEP;
    fm_v = cod_pkg::FM_KEEP;
    fm_d = cod_pkg::FM_KEEP;
    fm_h = cod_pkg::FM_KEEP;
    case (op)
      cod_pkg::OP_AND, cod_pkg::OP_WIDE_AND_OP, cod_pkg::OP_CLEAR_BIT_OP, cod_pkg::OP_SET_BIT_OP:
      begin
        fm_z = cod_pkg::FM_RESULT;
        fm_s = cod_pkg::FM_RESULT;
        fm_v = cod_pkg::FM_CLEAR;
      end
      cod_pkg::OP_BIT_REVERSE_OP:
      begin
        fm_c = cod_pkg::FM_UNDEF;
        fm_z = cod_pkg::FM_RESULT;
        fm_s = cod_pkg::FM_RESULT;
        fm_v = cod_pkg::FM_CLEAR;
      end
      cod_pkg::OP_CCF:
      begin
        fm_c = cod_pkg::FM_INVERT;
      end
      default:
      begin
        fm_c = cod_pkg::FM_KEEP; // Lock, branch, call: no flags change
      end
    endcase
  end

endmodule : cod_flag_map

// ===== tb/cod_decoder_asserts.sv
`timescale 1ns/1ps
// Ties each decoded class except add to some of its length, operation and flag effects
module cod_decoder_asserts (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic dec_valid,
  input wire logic [7:0] dec_opcode,
  input cod_pkg::cod_op_e dec_op,
  input wire logic [2:0] dec_len,
  input wire logic dec_pol,
  input wire logic src_work,
  input wire logic [11:0] src_addr,
  input wire logic [7:0] dec_sp_dec,
  input cod_pkg::cod_flag_e fm_c,
  input cod_pkg::cod_flag_e fm_z,
  input cod_pkg::cod_flag_e fm_s,
  input cod_pkg::cod_flag_e fm_v,
  input cod_pkg::cod_flag_e fm_d,
  input cod_pkg::cod_flag_e fm_h,
  input wire logic irq_block
);
  // Flags other than carry left alone
  logic keep_rest;
  // Zero, sign and overflow from a logic result
  logic logic_zsv;
  assign keep_rest = fm_z == cod_pkg::FM_KEEP && fm_s == cod_pkg::FM_KEEP && fm_v == cod_pkg::FM_KEEP
    && fm_d == cod_pkg::FM_KEEP && fm_h == cod_pkg::FM_KEEP;
  assign logic_zsv = fm_z == cod_pkg::FM_RESULT && fm_s == cod_pkg::FM_RESULT && fm_v == cod_pkg::FM_CLEAR;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  // Completed decode of one opcode
  sequence s_dec(opc);
    dec_valid && dec_opcode == opc;
  endsequence
  // The six plain AND forms
  sequence s_and;
    dec_valid && dec_opcode >= cod_pkg::OPC_AND_WW && dec_opcode <= cod_pkg::OPC_AND_IRIM;
  endsequence
  // Both extended AND forms
  sequence s_wide_and_op;
    dec_valid && (dec_opcode == cod_pkg::OPC_WIDE_AND_OP_EE || dec_opcode == cod_pkg::OPC_WIDE_AND_OP_EIM);
  endsequence
  // Both bit test branch forms
  sequence s_btj;
    dec_valid && (dec_opcode == cod_pkg::OPC_BTJ_W || dec_opcode == cod_pkg::OPC_BTJ_IW);
  endsequence
  and_flags_a: assert property (s_and |-> dec_op == cod_pkg::OP_AND && logic_zsv && fm_c == cod_pkg::FM_KEEP)
    else $error("AND flag effects wrong");
  wide_and_a: assert property (s_wide_and_op |-> dec_op == cod_pkg::OP_WIDE_AND_OP && dec_len == 3'h4 && logic_zsv)
    else $error("wide AND decode wrong");
  lock_window_a: assert property (s_dec(cod_pkg::OPC_LOCK) |-> dec_len == 3'h1 && keep_rest ##1 irq_block)
    else $error("lock did not open window");
  lock_end_a: assert property ($fell(irq_block) |-> $past(dec_valid))
    else $error("lock window closed without a decode");
  bit_write_a: assert property (s_dec(cod_pkg::OPC_BITW) |-> dec_len == 3'h2 && logic_zsv
    && dec_op == (dec_pol ? cod_pkg::OP_SET_BIT_OP : cod_pkg::OP_CLEAR_BIT_OP))
    else $error("bit write decode wrong");
  bit_reverse_a: assert property (s_dec(cod_pkg::OPC_BIT_REVERSE_OP) |-> dec_len == 3'h2 && fm_c == cod_pkg::FM_UNDEF
    && logic_zsv)
    else $error("bit reverse decode wrong");
  bit_branch_a: assert property (s_btj |-> dec_len == 3'h3 && keep_rest && fm_c == cod_pkg::FM_KEEP
    && dec_op == (dec_pol ? cod_pkg::OP_BRANCH_IF_BIT_SET : cod_pkg::OP_BRANCH_IF_BIT_CLEAR))
    else $error("bit branch decode wrong");
  call_stack_a: assert property (s_dec(cod_pkg::OPC_CALL_DA) |-> dec_op == cod_pkg::OP_CALL
    && dec_len == 3'h3 && dec_sp_dec == 8'h02)
    else $error("call decode wrong");
  carry_flip_a: assert property (s_dec(cod_pkg::OPC_CCF) |-> dec_len == 3'h1 && keep_rest
    && fm_c == cod_pkg::FM_INVERT)
    else $error("carry flip decode wrong");
  work_field_a: assert property (dec_valid && src_work |-> src_addr[11:4] == 8'h00)
    else $error("working register address too wide");
endmodule : cod_decoder_asserts

bind cod_decoder cod_decoder_asserts i_chk (.mclk(mclk), .rstn(rstn), .dec_valid(dec_valid),
  .dec_opcode(dec_opcode), .dec_op(dec_op), .dec_len(dec_len), .dec_pol(dec_pol), .src_work(src_work),
  .src_addr(src_addr), .dec_sp_dec(dec_sp_dec), .fm_c(fm_c), .fm_z(fm_z), .fm_s(fm_s), .fm_v(fm_v),
  .fm_d(fm_d), .fm_h(fm_h), .irq_block(irq_block));

// ===== tb/cod_prog_mem.sv
`timescale 1ns/1ps
// Program memory: offers one byte or one idle cycle per call
module cod_prog_mem (
  input wire logic mclk,
  output logic byte_valid,
  output logic [7:0] byte_data
);
  // Last byte offered, so idle cycles can show its inverse
  logic [7:0] last_q;
  initial
  begin
    byte_valid = 1'h0;
    byte_data = 8'h5A;
    last_q = 8'hA5;
  end
  // Each call owns exactly one cycle, so no signal is driven twice in a step
  task put(input logic [7:0] b, input logic v);
    byte_valid = v;
    byte_data = v ? b : ~last_q;
    if (v)
      last_q = b;
    @(posedge mclk);
    #1;
  endtask : put
endmodule : cod_prog_mem

// ===== tb/cod_decoder_test.sv
`timescale 1ns/1ps
// Random instruction stream with fixed corner cases, checked field by field
module cod_decoder_test;
  logic mclk;
  logic rstn;
  logic byte_valid;
  logic [7:0] byte_data;
  logic pc_load;
  logic [15:0] pc_load_addr;
  logic dec_valid, dec_illegal, dst_work, src_work, dec_pol, pair_err, irq_block;
  logic [7:0] dec_opcode, dec_imm, dec_sp_dec, dec_disp;
  cod_pkg::cod_mode_e dst_mode, src_mode;
  logic [2:0] dec_len, dec_bit;
  logic [11:0] dst_addr, src_addr;
  logic [15:0] dec_target, dec_next_pc;
  cod_pkg::cod_op_e dec_op;
  cod_pkg::cod_flag_e fm_c, fm_z, fm_s, fm_v, fm_d, fm_h;
  int failures;
  int checks_done;
  int cyc;
  logic [31:0] seed;
  logic [15:0] pc_a;
  logic [7:0] r1, r2, r3;
  // Expected flag effects, carry first
  localparam logic [17:0] FL_AND = {cod_pkg::FM_KEEP, cod_pkg::FM_RESULT, cod_pkg::FM_RESULT,
    cod_pkg::FM_CLEAR, cod_pkg::FM_KEEP, cod_pkg::FM_KEEP};
  localparam logic [17:0] FL_REV = {cod_pkg::FM_UNDEF, FL_AND[14:0]};
  localparam logic [17:0] FL_CCF = {cod_pkg::FM_INVERT, 15'h0000};
  localparam logic [17:0] FL_KEEP = 18'h00000;

  cod_prog_mem i_mem (.mclk, .byte_valid, .byte_data);
  cod_decoder i_dut (.mclk, .rstn, .byte_valid, .byte_data, .pc_load, .pc_load_addr, .dec_valid,
    .dec_illegal, .dec_opcode, .dec_op, .dec_len, .dst_mode, .dst_work, .dst_addr, .src_mode,
    .src_work, .src_addr, .dec_imm, .dec_bit, .dec_pol, .dec_disp, .dec_target, .dec_next_pc,
    .dec_sp_dec, .pair_err, .fm_c, .fm_z, .fm_s, .fm_v, .fm_d, .fm_h, .irq_block);

  // Free-running clock
  initial
  begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  // Hang guard: the run needs well under a thousand cycles
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      failures++;
      end_sim();
    end
  end
  // Advance the xorshift generator
  task rnd;
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
  endtask : rnd
  // Register field: escape nibble gives a working register
  function automatic logic [12:0] exp_reg(input logic [7:0] b);
    return (b[7:4] == 4'hE) ? {1'h1, 8'h00, b[3:0]} : {1'h0, 4'h0, b};
  endfunction : exp_reg
  // Branch target: address after a three-byte instruction plus signed displacement
  function automatic logic [15:0] exp_br(input logic [15:0] a, input logic [7:0] d);
    return a + 16'h0003 + {{8{d[7]}}, d};
  endfunction : exp_br
  // Value compare
  task chk(input string nm, input logic [17:0] e, input logic [17:0] g);
    checks_done++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Flag effect compare
  task chk_fl(input logic [17:0] e);
    chk("flags", e, {fm_c, fm_z, fm_s, fm_v, fm_d, fm_h});
  endtask : chk_fl
  // Send a whole instruction, stalling at random before each byte
  task instr(input logic [31:0] b, input int n);
    for (int k = 0; k < n; k++)
    begin
      rnd();
      if (seed[1:0] == 2'h0)
        i_mem.put(8'h00, 1'h0);
      i_mem.put(b[31 - 8 * k -: 8], 1'h1);
    end
    chk("dec_valid", 1'h1, dec_valid);
    chk("dec_len", n[2:0], dec_len);
  endtask : instr
  // Redirect the fetch address for one idle cycle
  task load(input logic [15:0] a);
    pc_load = 1'h1;
    pc_load_addr = a;
    i_mem.put(8'h00, 1'h0);
    pc_load = 1'h0;
  endtask : load
  // Verdict and end of run
  task end_sim;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  // Main sequence
  initial
  begin
    rstn = 1'h0;
    pc_load = 1'h0;
    pc_load_addr = 16'h0000;
    seed = 32'h2F76;
    failures = 0;
    checks_done = 0;
    cyc = 0;
    repeat (5) @(posedge mclk);
    #1;
    rstn = 1'h1;
    // Register add with escaped source
    instr(32'h04E84300, 3);
    chk("src", 13'h1008, {src_work, src_addr});
    chk("dst", 13'h0043, {dst_work, dst_addr});
    for (int i = 0; i < 8; i++)
    begin
      rnd();
      {r3, r2, r1} = seed[23:0];
      pc_a = seed[31:16];
      // Odd passes use the escape nibble, one pass the top value
      if (i[0])
        r1 = {4'hE, r1[3:0]};
      if (i == 2)
        r1 = 8'hFF;
      instr({8'h54, r1, r2, 8'h00}, 3);
      chk("src", exp_reg(r1), {src_work, src_addr});
      chk("dst", exp_reg(r2), {dst_work, dst_addr});
      chk("modes", {cod_pkg::MD_REG, cod_pkg::MD_REG}, {dst_mode, src_mode});
      chk("opcode", 8'h54, dec_opcode);
      instr({8'h58, r1, r2, r3}, 4);
      chk("src", {r1, r2[7:4]}, src_addr);
      chk("dst", {r2[3:0], r3}, dst_addr);
      chk_fl(FL_AND);
      instr({8'h59, r1, r2, r3}, 4);
      chk("imm", r1, dec_imm);
      instr({8'h56, r1, r2, 8'h00}, 3);
      chk("imm", r2, dec_imm);
      chk_fl(FL_AND);
      instr({8'hE2, r1, 16'h0000}, 2);
      chk("bit", r1[6:4], dec_bit);
      chk("pol", r1[7], dec_pol);
      chk("op", r1[7] ? cod_pkg::OP_SET_BIT_OP : cod_pkg::OP_CLEAR_BIT_OP, dec_op);
      instr({8'hD5, r1, 16'h0000}, 2);
      chk_fl(FL_REV);
      instr({8'hD4, r1, 16'h0000}, 2);
      chk("pair_err", r1[0], pair_err);
      load(pc_a);
      instr({8'hF6, r1, r2, 8'h00}, 3);
      chk("target", exp_br(pc_a, r2), dec_target);
      chk("disp", r2, dec_disp);
      chk("op", r1[7] ? cod_pkg::OP_BRANCH_IF_BIT_SET : cod_pkg::OP_BRANCH_IF_BIT_CLEAR, dec_op);
      chk_fl(FL_KEEP);
      load(pc_a);
      instr({8'hD6, r2, r3, 8'h00}, 3);
      chk("target", {r2, r3}, dec_target);
      chk("next_pc", pc_a + 16'h0003, dec_next_pc);
      chk("sp_dec", 8'h02, dec_sp_dec);
    end
    // Lock then three carry flips; window closes one edge after the third
    instr(32'h2F000000, 1);
    chk_fl(FL_KEEP);
    for (int i = 0; i < 3; i++)
    begin
      instr(32'hEF000000, 1);
      chk_fl(FL_CCF);
      chk("irq_block", 1'h1, irq_block);
    end
    i_mem.put(8'h00, 1'h0);
    chk("irq_block", 1'h0, irq_block);
    // Abort a partial add, then an opcode outside the subset
    i_mem.put(8'h04, 1'h1);
    i_mem.put(8'hE8, 1'h1);
    load(16'h1234);
    instr(32'h00000000, 1);
    chk("illegal", 1'h1, dec_illegal);
    chk("next_pc", 16'h1235, dec_next_pc);
    end_sim();
  end
endmodule : cod_decoder_test
